// [ufc_pkg.sv]
// constants, types and register map shared by the uart flow control design
// How it works
// - auto rts flow control runs only while enhanced_function bit 6 is set
// - host sets modem_control bit 1 to assert rts; auto control starts from there
// - rts low-to-high with interrupt_enable bit 6 sets interrupt_status bit 5
// - under auto rts, receive data interrupt fires at the receive trigger level
// - rts goes high only when receive fill reaches the upper hysteresis limit
// - rts returns low once reads drain the fifo to the lower limit
// - receiver keeps storing characters while rts is high until fifo is full
// - fixed tables use next higher and next lower levels as hysteresis limits
// - auto cts transmit gating runs only while enhanced_function bit 7 is set
// - cts going high with interrupt_enable bit 7 sets interrupt_status bit 5
// - on cts high the transmitter finishes the stop bit then waits for cts low
// - modem_control bit 4 selects internal loopback, other functions stay normal
// - in loopback the transmit shift output feeds the receive shift input
// - in loopback tx, rts and dtr pins are held and modem inputs ignored
// - auto rts and cts flow control are switched off during loopback
// - parallel mode uses three address lines; serial mode gives no register access
// - line_control bit 7 clear: address 0 holding registers, address 1 interrupt_enable
// - divisor latch open with zero divisor: addresses 0 and 1 read revision and id
// - line_control 0xBF: address 0 trigger/level, 1 feature_control, 2 enhanced_function
// - address 7: feature_control bit 6 picks scratch_pad or fifo level/mode select
// - line_control not 0xBF: address 2 reads interrupt_status, writes fifo_control
package ufc_pkg;
	// register addresses
	localparam logic [2:0] ADR_DATA = 3'h0;
	localparam logic [2:0] ADR_IER = 3'h1;
	localparam logic [2:0] ADR_ISR = 3'h2;
	localparam logic [2:0] ADR_LCR = 3'h3;
	localparam logic [2:0] ADR_MCR = 3'h4;
	localparam logic [2:0] ADR_LSR = 3'h5;
	localparam logic [2:0] ADR_MSR = 3'h6;
	localparam logic [2:0] ADR_SPR = 3'h7;
	localparam logic [7:0] LCR_ENH_KEY = 8'hBF;
	localparam logic [7:0] REG_RST = 8'h00;
	// field positions
	localparam int LCR_DIV_BIT = 7;
	localparam int EFR_CTS_BIT = 7;
	localparam int EFR_RTS_BIT = 6;
	localparam int EFR_ENH_BIT = 4;
	localparam int IER_CTS_BIT = 7;
	localparam int IER_RTS_BIT = 6;
	localparam int IER_RX_BIT = 0;
	localparam int IER_TX_BIT = 1;
	localparam int ISR_FLOW_BIT = 5;
	localparam int MCR_LOOP_BIT = 4;
	localparam int MCR_RTS_BIT = 1;
	localparam int MCR_DTR_BIT = 0;
	localparam int FEATURE_CONTROL_SEL_BIT = 6;
	localparam int FEATURE_CONTROL_PROG_BIT = 7;
	localparam int FCR_EN_BIT = 0;
	localparam int FCR_RXCLR_BIT = 1;
	localparam int FCR_TXCLR_BIT = 2;
	// bit timing in 16x ticks
	localparam logic [3:0] TICK_LAST = 4'hF;
	localparam logic [3:0] TICK_SAMPLE = 4'h7;
	localparam logic [3:0] STOP_IDX = 4'h9;
	// fifo and fixed trigger table
	localparam int FIFO_DEPTH = 8;
	localparam int RX_TRIG_TBL [4] = '{1, 2, 4, 6};
	// decoded register target
	typedef enum logic [3:0] {
		SEL_NONE, SEL_HOLD, SEL_DLL, SEL_DLM, SEL_IER, SEL_ISR, SEL_LCR, SEL_MCR,
		SEL_LSR, SEL_MSR, SEL_SPR, SEL_LVL, SEL_TRG, SEL_FEATURE_CONTROL, SEL_EFR
	} ufc_sel_e;
	typedef enum logic [1:0] {TX_IDLE = 2'b01, TX_SHIFT = 2'b10} ufc_tx_e;
	typedef enum logic [1:0] {RX_IDLE = 2'b01, RX_BUSY = 2'b10} ufc_rx_e;
	// host bus request
	typedef struct packed {
		logic [2:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} ufc_bus_s;
endpackage

// [ufc_fifo.sv]
// parameterised synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
module ufc_fifo #(
	parameter int W = 8,
	parameter int D = 8,
	localparam int AW = $clog2(D),
	localparam int CW = $clog2(D + 1)
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic clr_i,
	// fill side
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [W-1:0] in_data_i,
	// drain side
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [W-1:0] out_data_o,
	output logic [CW-1:0] count_o
);
	logic [W-1:0] mem [D];
	logic [AW-1:0] wp;
	logic [AW-1:0] rp;
	logic push;
	logic pop;
	// handshake terms
	assign in_ready_o = count_o != CW'(D);
	assign out_valid_o = count_o != '0;
	assign push = in_valid_i && in_ready_o;
	assign pop = out_ready_i && out_valid_o;
	assign out_data_o = mem[rp];
	// pointers and fill count
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			wp <= '0;
			rp <= '0;
			count_o <= '0;
		end else if (clr_i) begin
			wp <= '0;
			rp <= '0;
			count_o <= '0;
		end else begin
			if (push)
				wp <= AW'(wp + 1'b1);
			if (pop)
				rp <= AW'(rp + 1'b1);
			count_o <= CW'(count_o + CW'(push) - CW'(pop));
		end
	end
	// storage
	always_ff @(posedge clk_i) begin
		if (push)
			mem[wp] <= in_data_i;
	end
endmodule

// [ufc_uart_top.sv]
// enhanced uart with auto rts/cts flow control, loopback and register decode
`timescale 1ns/1ps
module ufc_uart_top
	import ufc_pkg::*;
#(
	parameter int DEPTH = FIFO_DEPTH,
	parameter logic [7:0] REV_CODE = 8'h01, // arbitrary value
	parameter logic [7:0] ID_CODE = 8'h5A // arbitrary value
) (
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_b_i,
	// host register bus
	input wire logic serial_mode_i,
	input wire ufc_bus_s bus_i,
	output logic [7:0] rd_data_o,
	output logic irq_o,
	output logic txrdy_b_o,
	// serial and modem pins
	input wire logic rx_i,
	input wire logic cts_b_i,
	input wire logic dsr_b_i,
	input wire logic cd_b_i,
	input wire logic ri_b_i,
	output logic tx_o,
	output logic rts_b_o,
	output logic dtr_b_o
);
	localparam int LW = $clog2(DEPTH + 1);

	// register target for an address under the current line_control
	function automatic ufc_sel_e decode(input logic [2:0] a, input logic [7:0] l,
		input logic [7:0] f);
		logic enh;
		enh = l == LCR_ENH_KEY;
		case (a)
			ADR_DATA: decode = enh ? SEL_TRG : (l[LCR_DIV_BIT] ? SEL_DLL : SEL_HOLD);
			ADR_IER: decode = enh ? SEL_FEATURE_CONTROL : (l[LCR_DIV_BIT] ? SEL_DLM : SEL_IER);
			ADR_ISR: decode = enh ? SEL_EFR : SEL_ISR;
			ADR_LCR: decode = SEL_LCR;
			ADR_MCR: decode = enh ? SEL_NONE : SEL_MCR;
			ADR_LSR: decode = enh ? SEL_NONE : SEL_LSR;
			ADR_MSR: decode = enh ? SEL_NONE : SEL_MSR;
			ADR_SPR: decode = enh ? SEL_NONE : (f[FEATURE_CONTROL_SEL_BIT] ? SEL_LVL : SEL_SPR);
			default: decode = SEL_NONE;
		endcase
	endfunction

	logic [7:0] line_control;
	logic [7:0] modem_control;
	logic [7:0] interrupt_enable;
	logic [7:0] enhanced_function;
	logic [7:0] feature_control;
	logic [7:0] scratch_pad;
	logic [7:0] enhanced_mode_select;
	logic [7:0] fifo_trigger_level;
	logic [7:0] fifo_control;
	logic [7:0] baud_divisor_low;
	logic [7:0] baud_divisor_high;
	ufc_sel_e sel;
	logic wr_go;
	logic rd_go;
	logic loop;
	logic div_zero;
	logic [15:0] baud_cnt;
	logic tick;
	logic tick_hit;
	ufc_tx_e tx_st;
	logic [9:0] tx_shift_register;
	logic [3:0] tx_sub;
	logic [3:0] tx_bit;
	logic tx_line;
	logic tx_load;
	logic tx_iready;
	logic tx_ovalid;
	logic [7:0] tx_dout;
	logic [LW-1:0] tx_cnt;
	logic cts_block;
	ufc_rx_e rx_st;
	logic [7:0] rx_shift_register;
	logic [3:0] rx_sub;
	logic [3:0] rx_bit;
	logic rx_in;
	logic rx_push;
	logic rx_iready;
	logic rx_ovalid;
	logic [7:0] rx_dout;
	logic [LW-1:0] rx_cnt;
	logic rx_pop;
	logic overrun;
	int t_lvl;
	int u_lvl;
	int l_lvl;
	int h_lvl;
	logic [LW-1:0] trig;
	logic [LW-1:0] upper;
	logic [LW-1:0] lower;
	logic auto_rts;
	logic flow_off;
	logic rts_level_b;
	logic rts_prev;
	logic cts_prev;
	logic rts_event;
	logic cts_event;
	logic flow_flag;
	logic rx_trig_int;
	logic tx_empty_int;
	logic [7:0] isr_val;
	logic [7:0] lsr_val;
	logic [7:0] msr_val;
	logic [3:0] modem_in;
	logic [7:0] next_rd_data;

	// decode, no access at all in serial mode
	assign sel = decode(bus_i.addr, line_control, feature_control);
	assign wr_go = bus_i.wr && !serial_mode_i;
	assign rd_go = bus_i.rd && !serial_mode_i;
	assign loop = modem_control[MCR_LOOP_BIT];
	assign div_zero = baud_divisor_low == 8'h00 && baud_divisor_high == 8'h00;

	// host writes into control registers
	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			line_control <= REG_RST;
			modem_control <= REG_RST;
			interrupt_enable <= REG_RST;
			enhanced_function <= REG_RST;
			feature_control <= REG_RST;
			scratch_pad <= REG_RST;
			enhanced_mode_select <= REG_RST;
			fifo_trigger_level <= REG_RST;
			fifo_control <= REG_RST;
			baud_divisor_low <= REG_RST;
			baud_divisor_high <= REG_RST;
		end else if (wr_go) begin
			case (sel)
				SEL_LCR: line_control <= bus_i.wdata;
				SEL_MCR: modem_control <= bus_i.wdata;
				// upper enables lock until enhanced bit 4 is set
				SEL_IER: interrupt_enable <= enhanced_function[EFR_ENH_BIT] ? bus_i.wdata :
					{interrupt_enable[7:4], bus_i.wdata[3:0]};
				SEL_ISR: fifo_control <= bus_i.wdata;
				SEL_SPR: scratch_pad <= bus_i.wdata;
				SEL_LVL: enhanced_mode_select <= bus_i.wdata;
				SEL_TRG: fifo_trigger_level <= bus_i.wdata;
				SEL_FEATURE_CONTROL: feature_control <= bus_i.wdata;
				SEL_EFR: enhanced_function <= bus_i.wdata;
				SEL_DLL: baud_divisor_low <= bus_i.wdata;
				SEL_DLM: baud_divisor_high <= bus_i.wdata;
				default: ;
			endcase
		end
	end

	// read mux
	always_comb begin
		next_rd_data = 8'h00;
		case (sel)
			SEL_HOLD: next_rd_data = rx_dout;
			SEL_DLL: next_rd_data = div_zero ? REV_CODE : baud_divisor_low;
			SEL_DLM: next_rd_data = div_zero ? ID_CODE : baud_divisor_high;
			SEL_IER: next_rd_data = interrupt_enable;
			SEL_ISR: next_rd_data = isr_val;
			SEL_LCR: next_rd_data = line_control;
			SEL_MCR: next_rd_data = modem_control;
			SEL_LSR: next_rd_data = lsr_val;
			SEL_MSR: next_rd_data = msr_val;
			SEL_SPR: next_rd_data = scratch_pad;
			SEL_LVL: next_rd_data = 8'(rx_cnt);
			SEL_TRG: next_rd_data = 8'(rx_cnt);
			SEL_FEATURE_CONTROL: next_rd_data = feature_control;
			SEL_EFR: next_rd_data = enhanced_function;
			default: next_rd_data = 8'h00;
		endcase
	end

	// read data register, held until the next read
	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i)
			rd_data_o <= 8'h00;
		else if (rd_go)
			rd_data_o <= next_rd_data;
	end

	// 16x baud tick from the divisor, stopped while divisor is zero
	assign tick_hit = !div_zero && baud_cnt == 16'({baud_divisor_high, baud_divisor_low} - 16'h0001);
	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			baud_cnt <= 16'h0000;
			tick <= 1'b0;
		end else begin
			baud_cnt <= (tick_hit || div_zero) ? 16'h0000 : 16'(baud_cnt + 16'h0001);
			tick <= tick_hit;
		end
	end

	// transmit fifo fed by host writes to the holding register
	ufc_fifo #(.W(8), .D(DEPTH)) u_tx_fifo (
		.clk_i(sys_clk_i),
		.rst_b_i(rst_b_i),
		.clr_i(wr_go && sel == SEL_ISR && bus_i.wdata[FCR_TXCLR_BIT]),
		.in_valid_i(wr_go && sel == SEL_HOLD),
		.in_ready_o(tx_iready),
		.in_data_i(bus_i.wdata),
		.out_valid_o(tx_ovalid),
		.out_ready_i(tx_load),
		.out_data_o(tx_dout),
		.count_o(tx_cnt)
	);

	// new character only starts when cts does not block
	assign cts_block = enhanced_function[EFR_CTS_BIT] && cts_b_i && !loop;
	assign tx_load = tx_st == TX_IDLE && tx_ovalid && !cts_block;
	assign tx_line = tx_shift_register[0];

	// transmitter: start, 8 data, stop; always finishes the stop bit
	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			tx_st <= TX_IDLE;
			tx_shift_register <= 10'h3FF;
			tx_sub <= 4'h0;
			tx_bit <= 4'h0;
		end else begin
			case (tx_st)
				TX_IDLE: begin
					if (tx_load) begin
						tx_shift_register <= {1'b1, tx_dout, 1'b0};
						tx_sub <= 4'h0;
						tx_bit <= 4'h0;
						tx_st <= TX_SHIFT;
					end
				end
				TX_SHIFT: begin
					if (tick) begin
						tx_sub <= 4'(tx_sub + 4'h1);
						if (tx_sub == TICK_LAST) begin
							tx_shift_register <= {1'b1, tx_shift_register[9:1]};
							if (tx_bit == STOP_IDX)
								tx_st <= TX_IDLE;
							else
								tx_bit <= 4'(tx_bit + 4'h1);
						end
					end
				end
				default: tx_st <= TX_IDLE;
			endcase
		end
	end

	// receive input, looped from the transmit shifter in loopback
	assign rx_in = loop ? tx_line : rx_i;

	// receiver: start validated mid-bit, data sampled mid-bit
	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rx_st <= RX_IDLE;
			rx_shift_register <= 8'h00;
			rx_sub <= 4'h0;
			rx_bit <= 4'h0;
		end else begin
			case (rx_st)
				RX_IDLE: begin
					if (tick && !rx_in) begin
						rx_st <= RX_BUSY;
						rx_sub <= 4'h1;
						rx_bit <= 4'h0;
					end
				end
				RX_BUSY: begin
					if (tick) begin
						rx_sub <= 4'(rx_sub + 4'h1);
						if (rx_sub == TICK_SAMPLE) begin
							if ((rx_bit == 4'h0 && rx_in) || rx_bit == STOP_IDX)
								rx_st <= RX_IDLE;
							else if (rx_bit != 4'h0)
								rx_shift_register <= {rx_in, rx_shift_register[7:1]};
						end
						if (rx_sub == TICK_LAST)
							rx_bit <= 4'(rx_bit + 4'h1);
					end
				end
				default: rx_st <= RX_IDLE;
			endcase
		end
	end

	// character complete with a good stop bit
	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i)
			rx_push <= 1'b0;
		else
			rx_push <= tick && rx_st == RX_BUSY && rx_sub == TICK_SAMPLE &&
				rx_bit == STOP_IDX && rx_in;
	end

	// receive fifo keeps filling regardless of rts, until full
	assign rx_pop = rd_go && sel == SEL_HOLD;
	ufc_fifo #(.W(8), .D(DEPTH)) u_rx_fifo (
		.clk_i(sys_clk_i),
		.rst_b_i(rst_b_i),
		.clr_i(wr_go && sel == SEL_ISR && bus_i.wdata[FCR_RXCLR_BIT]),
		.in_valid_i(rx_push),
		.in_ready_o(rx_iready),
		.in_data_i(rx_shift_register),
		.out_valid_o(rx_ovalid),
		.out_ready_i(rx_pop),
		.out_data_o(rx_dout),
		.count_o(rx_cnt)
	);

	// overrun when a character finds the fifo full, set wins over clear
	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i)
			overrun <= 1'b0;
		else
			overrun <= (rx_push && !rx_iready) || (overrun && !(rd_go && sel == SEL_LSR));
	end

	// trigger level and hysteresis limits
	always_comb begin
		t_lvl = 0;
		u_lvl = 0;
		l_lvl = 0;
		h_lvl = 0;
		if (feature_control[FEATURE_CONTROL_PROG_BIT]) begin
			t_lvl = int'(fifo_trigger_level);
			h_lvl = int'(enhanced_mode_select[5:4]);
			u_lvl = t_lvl + h_lvl;
			l_lvl = t_lvl - h_lvl;
		end else begin
			t_lvl = RX_TRIG_TBL[fifo_control[7:6]];
			u_lvl = (fifo_control[7:6] == 2'h3) ? DEPTH : RX_TRIG_TBL[int'(fifo_control[7:6]) + 1];
			l_lvl = (fifo_control[7:6] == 2'h0) ? 0 : RX_TRIG_TBL[int'(fifo_control[7:6]) - 1];
		end
		if (t_lvl > DEPTH)
			t_lvl = DEPTH;
		if (u_lvl > DEPTH)
			u_lvl = DEPTH;
		if (l_lvl < 0)
			l_lvl = 0;
		trig = LW'(t_lvl);
		upper = LW'(u_lvl);
		lower = LW'(l_lvl);
	end

	// auto rts band: off at upper limit, back on at lower limit
	assign auto_rts = enhanced_function[EFR_RTS_BIT] && !loop &&
		modem_control[MCR_RTS_BIT];
	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i)
			flow_off <= 1'b0;
		else if (!auto_rts)
			flow_off <= 1'b0;
		else if (!flow_off && rx_cnt >= upper)
			flow_off <= 1'b1;
		else if (flow_off && rx_cnt <= lower)
			flow_off <= 1'b0;
	end
	assign rts_level_b = !modem_control[MCR_RTS_BIT] || flow_off;

	// flow events and sticky status, set wins over the clearing read
	assign rts_event = rts_level_b && !rts_prev && interrupt_enable[IER_RTS_BIT];
	assign cts_event = cts_b_i && !cts_prev && interrupt_enable[IER_CTS_BIT] &&
		enhanced_function[EFR_CTS_BIT] && !loop;
	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rts_prev <= 1'b1;
			cts_prev <= 1'b1;
			flow_flag <= 1'b0;
		end else begin
			rts_prev <= rts_level_b;
			cts_prev <= cts_b_i;
			flow_flag <= rts_event || cts_event || (flow_flag && !(rd_go && sel == SEL_ISR));
		end
	end

	// interrupt sources and status values
	assign rx_trig_int = interrupt_enable[IER_RX_BIT] && rx_cnt >= trig && rx_ovalid;
	assign tx_empty_int = interrupt_enable[IER_TX_BIT] && !tx_ovalid;
	assign isr_val = {{2{fifo_control[FCR_EN_BIT]}}, flow_flag, 1'b0,
		rx_trig_int ? 4'h4 : (tx_empty_int ? 4'h2 : (flow_flag ? 4'h0 : 4'h1))};
	assign lsr_val = {1'b0, !tx_ovalid && tx_st == TX_IDLE, !tx_ovalid, 3'h0, overrun, rx_ovalid};
	// modem inputs ignored in loopback, fed from modem_control
	assign modem_in = loop ? {modem_control[3], modem_control[2], modem_control[MCR_DTR_BIT],
		modem_control[MCR_RTS_BIT]} : {!cd_b_i, !ri_b_i, !dsr_b_i, !cts_b_i};
	assign msr_val = {modem_in, 4'h0};

	// pin outputs; tx, rts and dtr held static in loopback, irq and txrdy keep updating
	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			tx_o <= 1'b1;
			rts_b_o <= 1'b1;
			dtr_b_o <= 1'b1;
			irq_o <= 1'b0;
			txrdy_b_o <= 1'b0;
		end else begin
			tx_o <= loop ? 1'b1 : tx_line;
			rts_b_o <= loop ? rts_b_o : rts_level_b;
			dtr_b_o <= loop ? dtr_b_o : !modem_control[MCR_DTR_BIT];
			irq_o <= !isr_val[0];
			txrdy_b_o <= !tx_iready;
		end
	end

	// checks
	sequence s_cts_hold;
		tx_st == TX_IDLE && tx_ovalid && cts_block;
	endsequence
	sequence s_rts_rise;
		rts_level_b && !rts_prev && interrupt_enable[IER_RTS_BIT];
	endsequence

	a_rts_needs_enable: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
		!enhanced_function[EFR_RTS_BIT] |=> !flow_off)
		else $error("auto rts active without enable");
	a_rts_start_state: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
		!modem_control[MCR_RTS_BIT] |-> rts_level_b && !auto_rts)
		else $error("rts asserted without modem control bit");
	a_rts_int_flag: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
		s_rts_rise |=> flow_flag && isr_val[ISR_FLOW_BIT])
		else $error("rts rise did not set status");
	a_rx_trig_code: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
		interrupt_enable[IER_RX_BIT] && rx_cnt >= trig && rx_ovalid |-> isr_val[3:0] == 4'h4)
		else $error("receive trigger interrupt missing");
	a_rts_upper_limit: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
		$rose(flow_off) |-> $past(rx_cnt) >= $past(upper))
		else $error("rts raised below upper limit");
	a_rts_lower_limit: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
		$fell(flow_off) && $past(auto_rts) |-> $past(rx_cnt) <= $past(lower))
		else $error("rts lowered above lower limit");
	a_cts_tx_hold: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
		s_cts_hold |-> !tx_load ##1 tx_st == TX_IDLE)
		else $error("transmit started while cts high");
	a_loop_pins_held: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
		loop && $past(loop) |-> tx_o && $stable(rts_b_o) && $stable(dtr_b_o))
		else $error("pins moved in loopback");
	a_serial_no_write: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
		serial_mode_i && bus_i.wr |=> $stable(line_control) && $stable(scratch_pad))
		else $error("register written in serial mode");
	a_rev_code_read: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
		rd_go && sel == SEL_DLL && div_zero |=> rd_data_o == REV_CODE)
		else $error("revision code not returned");
endmodule

// [ufc_remote.sv]
// remote uart model: sends one 8N1 character per request, request dropped while cts is high
`timescale 1ns/1ps
module ufc_remote (
	// clock
	input wire logic clk_i,
	// handshake and request
	input wire logic cts_b_i,
	input wire logic go_i,
	input wire logic [7:0] byte_i,
	// serial line
	output logic line_o,
	output logic busy_o
);
	logic [9:0] frame = 10'h3FF;
	logic [7:0] n = 8'h00;
	initial busy_o = 1'b0;
	// a new character starts only while cts is asserted, 16 clocks a bit
	always @(posedge clk_i) begin
		if (go_i && !busy_o && !cts_b_i) begin
			frame <= {1'b1, byte_i, 1'b0};
			n <= 8'h00;
			busy_o <= 1'b1;
		end else if (busy_o) begin
			n <= n + 8'h01;
			if (n[3:0] == 4'hF) frame <= {1'b1, frame[9:1]};
			if (n == 8'h9F) busy_o <= 1'b0;
		end
	end
	// line idles high between characters and through loopback
	assign line_o = busy_o ? frame[0] : 1'b1;
endmodule

// [tb_ufc_uart_top.sv]
// testbench for the uart flow control and register decode block
`timescale 1ns/1ps
module tb_ufc_uart_top;
	import ufc_pkg::*;
	localparam logic [7:0] REV = 8'h3C; // arbitrary value
	localparam logic [7:0] IDC = 8'hC3; // arbitrary value
	logic sys_clk_i = 1'b0;
	logic rst_b_i = 1'b0;
	logic serial_mode_i = 1'b0;
	ufc_bus_s bus_i = '0;
	logic cts_b_i = 1'b0;
	logic go = 1'b0;
	logic [7:0] gb = 8'h00;
	logic [7:0] rd_data_o, v;
	logic irq_o, txrdy_b_o, rx_i, tx_o, rts_b_o, dtr_b_o, busy;
	int err_count = 0;
	int cmp_count = 0;
	// 10 MHz clock
	always #50 sys_clk_i = ~sys_clk_i;
	ufc_uart_top #(.REV_CODE(REV), .ID_CODE(IDC)) dut (.sys_clk_i(sys_clk_i),
		.rst_b_i(rst_b_i), .serial_mode_i(serial_mode_i), .bus_i(bus_i),
		.rd_data_o(rd_data_o), .irq_o(irq_o), .txrdy_b_o(txrdy_b_o), .rx_i(rx_i),
		.cts_b_i(cts_b_i), .dsr_b_i(1'b1), .cd_b_i(1'b1), .ri_b_i(1'b1),
		.tx_o(tx_o), .rts_b_o(rts_b_o), .dtr_b_o(dtr_b_o));
	// remote sender, its cts crossed to our rts
	ufc_remote far (.clk_i(sys_clk_i), .cts_b_i(rts_b_o), .go_i(go), .byte_i(gb),
		.line_o(rx_i), .busy_o(busy));
	// compare and count
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
		cmp_count++;
		if (s !== e) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask
	// bus cycles, driven on falling edges
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(negedge sys_clk_i);
		bus_i = '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(negedge sys_clk_i);
		bus_i.wr = 1'b0;
	endtask
	task automatic rd(input logic [2:0] a);
		@(negedge sys_clk_i);
		bus_i = '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(negedge sys_clk_i);
		bus_i.rd = 1'b0;
		v = rd_data_o;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge sys_clk_i);
	endtask
	// one character from the remote, 160 clocks at divisor 1
	task automatic send(input logic [7:0] b);
		gb = b;
		go = 1'b1;
		cyc(1);
		go = 1'b0;
		cyc(170);
	endtask
	task automatic t_decode();
		chk("txrdy_b", 8'h00, {7'h0, txrdy_b_o});
		chk("dtr_b", 8'h01, {7'h0, dtr_b_o});
		wr(ADR_SPR, 8'h3C);
		rd(ADR_SPR);
		chk("scratch_pad", 8'h3C, v);
		wr(ADR_LCR, 8'h80);
		rd(ADR_DATA);
		chk("revision_code", REV, v);
		rd(ADR_IER);
		chk("identification_code", IDC, v);
		wr(ADR_DATA, 8'h01);
		serial_mode_i = 1'b1;
		wr(ADR_DATA, 8'h07);
		serial_mode_i = 1'b0;
		rd(ADR_DATA);
		chk("baud_divisor_low", 8'h01, v);
		wr(ADR_LCR, LCR_ENH_KEY);
		wr(ADR_ISR, 8'hD0);
		rd(ADR_ISR);
		chk("enhanced_function", 8'hD0, v);
		wr(ADR_LCR, 8'h00);
		wr(ADR_IER, 8'hC1);
		rd(ADR_IER);
		chk("interrupt_enable", 8'hC1, v);
		wr(ADR_ISR, 8'h01);
		$display("test decode done");
	endtask
	task automatic t_loop();
		int bad;
		bad = 0;
		wr(ADR_MCR, 8'h10);
		wr(ADR_DATA, 8'hA5);
		repeat (200) begin
			@(negedge sys_clk_i);
			if (tx_o !== 1'b1) bad++;
		end
		chk("tx_held", 8'h00, (bad > 255) ? 8'hFF : bad[7:0]);
		chk("dtr_held", 8'h01, {7'h0, dtr_b_o});
		rd(ADR_DATA);
		chk("loop_data", 8'hA5, v);
		wr(ADR_MCR, 8'h00);
		$display("test loopback done");
	endtask
	// fixed table, trigger 1: upper limit 2, lower limit 0
	task automatic t_rts();
		wr(ADR_MCR, 8'h02);
		cyc(3);
		chk("rts_on", 8'h00, {7'h0, rts_b_o});
		send(8'h11);
		chk("rts_first", 8'h00, {7'h0, rts_b_o});
		chk("irq_trig", 8'h01, {7'h0, irq_o});
		send(8'h22);
		chk("rts_upper", 8'h01, {7'h0, rts_b_o});
		rd(ADR_ISR);
		chk("rts_flag", 8'h01, {7'h0, v[ISR_FLOW_BIT]});
		rd(ADR_DATA);
		chk("rx_first", 8'h11, v);
		cyc(3);
		chk("rts_hold", 8'h01, {7'h0, rts_b_o});
		rd(ADR_DATA);
		chk("rx_second", 8'h22, v);
		cyc(3);
		chk("rts_lower", 8'h00, {7'h0, rts_b_o});
		$display("test auto rts done");
	endtask
	task automatic t_cts();
		int bad;
		bad = 0;
		cts_b_i = 1'b1;
		cyc(3);
		rd(ADR_ISR);
		chk("cts_flag", 8'h01, {7'h0, v[ISR_FLOW_BIT]});
		wr(ADR_DATA, 8'h5A);
		repeat (100) begin
			@(negedge sys_clk_i);
			if (tx_o !== 1'b1) bad++;
		end
		chk("tx_gated", 8'h00, (bad > 255) ? 8'hFF : bad[7:0]);
		cts_b_i = 1'b0;
		cyc(8);
		chk("tx_resume", 8'h00, {7'h0, tx_o});
		$display("test auto cts done");
	endtask
	// counts, verdict and end of run
	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	// main sequence
	initial begin
		cyc(16);
		rst_b_i = 1'b1;
		t_decode();
		t_loop();
		t_rts();
		t_cts();
		report_and_stop();
	end
	// watchdog, well past the roughly 730 cycles the tests need
	initial begin
		repeat (20000) @(posedge sys_clk_i);
		err_count++;
		report_and_stop();
	end
endmodule
